/* File: hw/idma_pkg.sv */
// Package for the indirect data memory addressing block.
// Assumes an 8-bit data memory of two banks, 128 locations each.
package idma_pkg;
    // ************************************************************
    // Address map constants
    // ************************************************************
    localparam logic [7:0] IDMA_ADDR_PORT_A = 8'h00;
    localparam logic [7:0] IDMA_ADDR_BANK0_PTR = 8'h01;
    localparam logic [7:0] IDMA_ADDR_PORT_B = 8'h02;
    localparam logic [7:0] IDMA_ADDR_PTR_B_LOW = 8'h03;
    localparam logic [7:0] IDMA_ADDR_PTR_B_BANK = 8'h04;
    localparam logic [7:0] IDMA_ADDR_PORT_C = 8'h0c;
    localparam logic [7:0] IDMA_ADDR_PTR_C_LOW = 8'h0d;
    localparam logic [7:0] IDMA_ADDR_PTR_C_BANK = 8'h0e;
    localparam logic [7:0] IDMA_SPECIAL_LIMIT = 8'h40;
    localparam logic [7:0] IDMA_BANK_COUNT = 8'h02;
    localparam logic [7:0] IDMA_READ_EMPTY = 8'h00;
    localparam logic [7:0] IDMA_RESET_VALUE = 8'h00;
    localparam int IDMA_DEPTH = 256;

    // Core access request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } idma_req_t;
endpackage

/* File: hw/idma_top.sv */
// Indirect addressing data memory: pointers, indirect ports, two banks.
// Assumes the core issues at most one access per cycle on the same clock.
// Behaviour
// - Indirect port addresses hold no storage
// - Port access redirected through its pointer
// - Port A reaches bank 0 only
// - Ports B and C reach any bank
// - Bank byte selects bank, low selects location
// - Indirect read of a port returns 00H
// - Indirect write of a port does nothing
// - Five pointers are ordinary read/write registers
// - Direct addressing reaches every bank
// - Two banks, special registers shared
// - Data memory starts at 00H
`timescale 1ns/1ps
`default_nettype none
module idma_top
    import idma_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire idma_req_t req,
    input wire logic [7:0] bank_select,
    output logic [7:0] rdata
);
    // ************************************************************
    // Reset synchroniser
    // ************************************************************
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ************************************************************
    // Address helpers
    // ************************************************************
    // Location inside a bank; bit 7 is not decoded, so nothing hides behind a port
    function automatic logic [7:0] in_bank(input logic [7:0] a);
        in_bank = {1'b0, a[6:0]};
    endfunction

    // True when a location names one of the indirect ports
    function automatic logic is_port(input logic [7:0] loc);
        is_port = (loc == IDMA_ADDR_PORT_A) || (loc == IDMA_ADDR_PORT_B) || (loc == IDMA_ADDR_PORT_C);
    endfunction

    // True when a location lies in the special area that every bank shares
    function automatic logic is_special(input logic [7:0] loc);
        is_special = (loc < IDMA_SPECIAL_LIMIT);
    endfunction

    // Special registers live below the limit and are shared by all banks
    function automatic logic [7:0] phys(input logic [7:0] bank, input logic [7:0] loc);
        phys = is_special(loc) ? loc : {bank[0], loc[6:0]};
    endfunction

    // ************************************************************
    // Storage and pointers
    // ************************************************************
    logic [7:0] mem [0:IDMA_DEPTH-1];
    logic [7:0] bank0_pointer;
    logic [7:0] pointer_b_low;
    logic [7:0] pointer_b_bank;
    logic [7:0] pointer_c_low;
    logic [7:0] pointer_c_bank;

    // ************************************************************
    // Effective address selection
    // ************************************************************
    // Location part of the request decides whether a port is addressed
    wire [7:0] req_loc = in_bank(req.addr);
    wire sel_a = (req_loc == IDMA_ADDR_PORT_A);
    wire sel_b = (req_loc == IDMA_ADDR_PORT_B);
    wire sel_c = (req_loc == IDMA_ADDR_PORT_C);
    wire indirect = sel_a | sel_b | sel_c;

    // Pointer contents as held at the start of this access
    wire [7:0] eff_loc =
        sel_a ? in_bank(bank0_pointer) :
        sel_b ? in_bank(pointer_b_low) :
        sel_c ? in_bank(pointer_c_low) :
        req_loc;

    // Port A is tied to bank 0, pairs use their bank byte, direct uses bank_select
    wire [7:0] eff_bank =
        sel_a ? 8'h00 :
        sel_b ? pointer_b_bank :
        sel_c ? pointer_c_bank :
        bank_select;

    // ************************************************************
    // Refusal of an access
    // ************************************************************
    // Shared area is reachable whatever the bank byte holds
    wire special = is_special(eff_loc);
    wire bank_ok = special || (eff_bank < IDMA_BANK_COUNT);
    // A pointer aimed at a port finds no storage there
    wire target_port = indirect && is_port(eff_loc);
    wire blocked = !bank_ok || target_port;
    wire [7:0] paddr = phys(eff_bank, eff_loc);
    wire do_write = req.wr && !blocked;
    wire do_read = req.rd;

    // ************************************************************
    // Pointer decode
    // ************************************************************
    // Physical address lands on one of the five pointers
    wire at_p0 = (paddr == IDMA_ADDR_BANK0_PTR);
    wire at_bl = (paddr == IDMA_ADDR_PTR_B_LOW);
    wire at_bb = (paddr == IDMA_ADDR_PTR_B_BANK);
    wire at_cl = (paddr == IDMA_ADDR_PTR_C_LOW);
    wire at_cb = (paddr == IDMA_ADDR_PTR_C_BANK);
    wire at_ptr = at_p0 | at_bl | at_bb | at_cl | at_cb;

    // Write strobes per pointer
    wire hit_p0 = do_write && at_p0;
    wire hit_bl = do_write && at_bl;
    wire hit_bb = do_write && at_bb;
    wire hit_cl = do_write && at_cl;
    wire hit_cb = do_write && at_cb;
    // Plain storage takes every other accepted write
    wire mem_we = do_write && !at_ptr;

    // Next pointer values: an accepted write replaces the register
    wire [7:0] next_bank0_pointer = hit_p0 ? req.wdata : bank0_pointer;
    wire [7:0] next_pointer_b_low = hit_bl ? req.wdata : pointer_b_low;
    wire [7:0] next_pointer_b_bank = hit_bb ? req.wdata : pointer_b_bank;
    wire [7:0] next_pointer_c_low = hit_cl ? req.wdata : pointer_c_low;
    wire [7:0] next_pointer_c_bank = hit_cb ? req.wdata : pointer_c_bank;

    // ************************************************************
    // Read path
    // ************************************************************
    // Pointer registers as seen by a read
    wire [7:0] ptr_value =
        at_p0 ? bank0_pointer :
        at_bl ? pointer_b_low :
        at_bb ? pointer_b_bank :
        at_cl ? pointer_c_low :
        pointer_c_bank;
    // Plain storage as seen by a read
    wire [7:0] mem_value = mem[paddr];
    // Refused accesses read empty; a same-cycle write is not yet visible
    wire [7:0] read_value =
        blocked ? IDMA_READ_EMPTY :
        at_ptr ? ptr_value :
        mem_value;

    // ************************************************************
    // Pointer registers
    // ************************************************************
    // Bank 0 pointer, written like any other register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bank0_pointer <= IDMA_RESET_VALUE;
        end else begin
            bank0_pointer <= next_bank0_pointer;
        end
    end

    // Port B location byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pointer_b_low <= IDMA_RESET_VALUE;
        end else begin
            pointer_b_low <= next_pointer_b_low;
        end
    end

    // Port B bank byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pointer_b_bank <= IDMA_RESET_VALUE;
        end else begin
            pointer_b_bank <= next_pointer_b_bank;
        end
    end

    // Port C location byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pointer_c_low <= IDMA_RESET_VALUE;
        end else begin
            pointer_c_low <= next_pointer_c_low;
        end
    end

    // Port C bank byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pointer_c_bank <= IDMA_RESET_VALUE;
        end else begin
            pointer_c_bank <= next_pointer_c_bank;
        end
    end

    // ************************************************************
    // Data memory
    // ************************************************************
    // Plain storage; port and pointer locations are never written here
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[paddr] <= req.wdata;
        end
    end

    // ************************************************************
    // Read data register
    // ************************************************************
    // Registered read data, one cycle after the request; holds otherwise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= IDMA_READ_EMPTY;
        end else if (do_read) begin
            rdata <= read_value;
        end
    end
endmodule // idma_top
`default_nettype wire

/* File: bench/idma_top_checker.sv */
// Port-level assertions for the indirect addressing block.
// Assumes one request per cycle and rdata registered on the read edge.
`timescale 1ns/1ps
`default_nettype none
module idma_top_checker
    import idma_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire idma_req_t req,
    input wire logic [7:0] bank_select,
    input wire logic [7:0] rdata
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    a_hold_idle: assert property (!req.rd |=> $stable(rdata))
        else $error("rdata moved without a read");
    a_port_a_empty: assert property (
        req.wr && !req.rd && req.addr == IDMA_ADDR_BANK0_PTR && req.wdata == IDMA_ADDR_PORT_A ##1
        req.rd && !req.wr && req.addr == IDMA_ADDR_PORT_A |=> rdata == IDMA_READ_EMPTY)
        else $error("port a read through itself not empty");
    a_port_b_empty: assert property (
        req.wr && !req.rd && req.addr == IDMA_ADDR_PTR_B_LOW && req.wdata == IDMA_ADDR_PORT_B ##1
        req.rd && !req.wr && req.addr == IDMA_ADDR_PORT_B |=> rdata == IDMA_READ_EMPTY)
        else $error("port b read through itself not empty");
    a_port_c_empty: assert property (
        req.wr && !req.rd && req.addr == IDMA_ADDR_PTR_C_LOW && req.wdata == IDMA_ADDR_PORT_C ##1
        req.rd && !req.wr && req.addr == IDMA_ADDR_PORT_C |=> rdata == IDMA_READ_EMPTY)
        else $error("port c read through itself not empty");
    a_ptr_readback: assert property (req.wr && !req.rd && req.addr == IDMA_ADDR_BANK0_PTR ##1
        req.rd && !req.wr && req.addr == IDMA_ADDR_BANK0_PTR |=> rdata == $past(req.wdata, 2))
        else $error("pointer readback wrong");
    a_mem_readback: assert property (
        req.wr && !req.rd && req.addr inside {[IDMA_SPECIAL_LIMIT:8'h7f]} && bank_select < IDMA_BANK_COUNT ##1
        req.rd && !req.wr && $stable(req.addr) && $stable(bank_select) |=> rdata == $past(req.wdata, 2))
        else $error("direct readback wrong");
    a_shared_low: assert property (req.wr && !req.rd && req.addr inside {[8'h10:8'h3f]} ##1
        req.rd && !req.wr && $stable(req.addr) |=> rdata == $past(req.wdata, 2))
        else $error("shared area differs by bank");
    a_reset_clear: assert property (disable iff (1'b0) !reset_n |-> rdata == IDMA_RESET_VALUE)
        else $error("rdata not clear in reset");
endmodule // idma_top_checker
bind idma_top idma_top_checker chk (.clk(clk), .reset_n(reset_n), .req(req), .bank_select(bank_select), .rdata(rdata));
`default_nettype wire

/* File: bench/idma_core_model.sv */
// Execution core model: issues one access per task call.
// Assumes requests change just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module idma_core_model
    import idma_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] rdata,
    output var idma_req_t req,
    output logic [7:0] bank_select
);
    initial req = '0;
    initial bank_select = 8'h00;
    // One request launched on an edge, taken on the next
    task drive(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] b);
        @(posedge clk);
        req <= '{rd: r, wr: w, addr: a, wdata: d};
        bank_select <= b;
    endtask
    // Read, then idle one cycle and pick up the registered data
    task read(input logic [7:0] a, input logic [7:0] b, output logic [7:0] v);
        drive(1'b1, 1'b0, a, 8'h00, b);
        drive(1'b0, 1'b0, 8'h00, 8'h00, b);
        #1 v = rdata;
    endtask
endmodule // idma_core_model
`default_nettype wire

/* File: bench/idma_top_tb.sv */
// Directed testbench for the indirect addressing block.
// Assumes the core model and checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module idma_top_tb;
    import idma_pkg::*;
    logic clk = 1'b0;
    logic reset_n;
    idma_req_t req;
    logic [7:0] bank_select;
    logic [7:0] rdata;
    logic [7:0] v;
    int bad_count = 0;
    int n_compared = 0;
    always #50 clk = ~clk;
    idma_top uut (.clk(clk), .reset_n(reset_n), .req(req), .bank_select(bank_select), .rdata(rdata));
    idma_core_model core (.clk(clk), .rdata(rdata), .req(req), .bank_select(bank_select));
    // Compare a seen value against the expected one
    task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Read one location and compare
    task rd(input logic [7:0] a, input logic [7:0] b, input logic [7:0] exp, input string what);
        core.read(a, b, v);
        check(v, exp, what);
    endtask
    task w(input logic [7:0] a, input logic [7:0] d, input logic [7:0] b);
        core.drive(1'b0, 1'b1, a, d, b);
    endtask
    task end_of_test();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Main sequence
    initial begin
        reset_n <= 1'b0; // Falling edge so the asynchronous reset takes hold at once
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        w(8'h01, 8'h45, 8'h00);
        rd(8'h01, 8'h00, 8'h45, "bank0_pointer");
        w(8'h45, 8'ha5, 8'h00);
        w(8'h45, 8'h5a, 8'h01);
        rd(8'h45, 8'h01, 8'h5a, "bank1 direct");
        rd(8'h00, 8'h01, 8'ha5, "indirect_port_a");
        w(8'h03, 8'h45, 8'h00);
        w(8'h04, 8'h01, 8'h00);
        rd(8'h02, 8'h00, 8'h5a, "indirect_port_b");
        w(8'h0d, 8'h45, 8'h00);
        w(8'h0e, 8'h00, 8'h01);
        rd(8'h0c, 8'h01, 8'ha5, "indirect_port_c");
        w(8'h20, 8'h3c, 8'h01);
        rd(8'h20, 8'h00, 8'h3c, "shared area");
        w(8'h01, 8'h00, 8'h00);
        rd(8'h00, 8'h00, 8'h00, "port a on itself");
        w(8'h00, 8'h77, 8'h00);
        rd(8'h01, 8'h00, 8'h00, "pointer after self write");
        w(8'h04, 8'h02, 8'h00);
        w(8'h02, 8'h33, 8'h00);
        rd(8'h02, 8'h00, 8'h00, "absent bank read");
        rd(8'h45, 8'h00, 8'ha5, "bank0 kept");
        rd(8'h45, 8'h01, 8'h5a, "bank1 kept");
        w(8'h03, 8'h02, 8'h00);
        rd(8'h02, 8'h00, 8'h00, "port b on itself");
        w(8'h0d, 8'h0c, 8'h00);
        rd(8'h0c, 8'h00, 8'h00, "port c on itself");
        w(8'h0c, 8'h99, 8'h00);
        rd(8'h0d, 8'h00, 8'h0c, "pointer c after self write");
        end_of_test();
    end
endmodule // idma_top_tb
`default_nettype wire
